// *** hdl/sdmc_map.svh ***
// Register offsets, field positions, reset values and timing of the step/dir controller
`ifndef SDMC_MAP_SVH
`define SDMC_MAP_SVH

// Timing
`define SDMC_CLK_HZ          25000000
`define SDMC_IDLE_MS         100
`define SDMC_BLINK_MS        250

// Register word indices
`define SDMC_REG_CTRL        4'h0
`define SDMC_REG_STATUS      4'h1
`define SDMC_REG_MASK        4'h2
`define SDMC_REG_POS         4'h3
`define SDMC_REG_SWITCH      4'h4
`define SDMC_REG_STATE       4'h5

// Control fields
`define SDMC_CTRL_EN_BIT     0
`define SDMC_CTRL_CLRPOS_BIT 1

// Reset values
`define SDMC_CTRL_EN_RST     1'b1
`define SDMC_MASK_RST        8'h00
`define SDMC_PLED_RST        1'b1

// Status and mask fields
`define SDMC_EV_UVOLT        0
`define SDMC_EV_OVOLT        1
`define SDMC_EV_PHOPEN       2
`define SDMC_EV_OVCUR        3
`define SDMC_EV_OVTEMP       4
`define SDMC_EV_ENCODER      5
`define SDMC_EV_IDLE         6
`define SDMC_EV_RELEASE      7

`endif

// *** hdl/sdmc_pkg.sv ***
// Types shared by the step/dir controller
package sdmc_pkg;

    typedef struct packed {
        logic        stepPrev;
        logic        relPrev;
        logic        ctrlEn;
        logic        idle;
        logic        stepStrobe;
        logic        stepUp;
        logic        coilEnable;
        logic [15:0] microPos;
        logic [15:0] stepsPerRev;
        logic [4:0]  runCurrent;
        logic [5:0]  currentCmd;
        logic [23:0] idleCnt;
        logic [23:0] blinkCnt;
        logic        blinkPhase;
        logic        powerLed;
        logic        faultLed;
        logic [7:0]  status;
        logic [7:0]  mask;
        logic [15:0] rdData;
    } sdmc_state_t;

endpackage : sdmc_pkg

// *** hdl/sdmc_sync.sv ***
// Two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module sdmc_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,   // System clock
    input  wire logic         rstN,   // Asynchronous reset, active low
    input  wire logic [W-1:0] din,    // Asynchronous levels
    output logic      [W-1:0] dout    // Synchronised levels
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule : sdmc_sync

// *** hdl/sdmc_motor_ctrl.sv ***
// Step/direction motor control: microstep position, current command, LEDs, registers
`timescale 1ns/1ps
`include "sdmc_map.svh"
module sdmc_motor_ctrl #(
    parameter int unsigned IDLE_CYCLES  = `SDMC_IDLE_MS * (`SDMC_CLK_HZ / 1000),
    parameter int unsigned BLINK_CYCLES = `SDMC_BLINK_MS * (`SDMC_CLK_HZ / 1000)
) (
    input  wire logic        mclk,             // 25 MHz clock
    input  wire logic        resetn,           // Async reset, active low
    input  wire logic        stepPulseIn,      // Step pin, falling edge steps
    input  wire logic        directionIn,      // Direction pin, high counts up
    input  wire logic        motorReleaseN,    // Release pin, active low
    input  wire logic [3:0]  currentSel,       // Current switches, bit0 first
    input  wire logic [3:0]  microstepSel,     // Microstep switches, bit0 first
    input  wire logic        underVoltage,     // Supply low fault
    input  wire logic        overVoltage,      // Supply high fault
    input  wire logic        phaseOpen,        // Open phase fault
    input  wire logic        phaseOverCurrent, // Phase overcurrent fault
    input  wire logic        phaseOverTemp,    // Phase overheat fault
    input  wire logic        encoderFault,     // Encoder fault
    input  wire logic [3:0]  regAddr,          // Register word index
    input  wire logic [15:0] regWrData,        // Write data
    input  wire logic        regWrEn,          // Write strobe
    input  wire logic        regRdEn,          // Read strobe
    output logic      [15:0] regRdData,        // Read data, cycle after strobe
    output logic             irq,              // Interrupt, level
    output logic      [15:0] microPos,         // Microstep position in revolution
    output logic             stepStrobe,       // One-cycle pulse per taken step
    output logic             stepUp,           // Sense of last step
    output logic             coilEnable,       // Phase current allowed
    output logic      [5:0]  currentCmd,       // Coil current, 50 mA units
    output logic      [4:0]  runCurrent,       // Selected run current, 0.1 A units
    output logic      [15:0] stepsPerRev,      // Selected resolution
    output logic             powerLed,         // Power indicator
    output logic             faultLed          // Fault indicator
);
    import sdmc_pkg::*;

    localparam sdmc_state_t ST_RST = '{ctrlEn: `SDMC_CTRL_EN_RST, mask: `SDMC_MASK_RST,
                                       powerLed: `SDMC_PLED_RST, default: '0};

    sdmc_state_t st;
    sdmc_state_t nxt;

    logic        rstN;
    logic        stepS;
    logic        dirS;
    logic        relS;
    logic [5:0]  faultS;
    logic [7:0]  swS;
    logic        faultActive;
    logic        stepFall;
    logic        stepTake;
    logic        wrCtrl;
    logic        wrStatus;
    logic        wrMask;
    logic [7:0]  events;
    logic [15:0] posInc;
    logic [15:0] posDec;

    // Run current in 0.1 A from {sw0,sw1,sw2,sw3}
    function automatic logic [4:0] cur_tenths(input logic [3:0] sw);
        logic [3:0] key;
        key = {sw[0], sw[1], sw[2], sw[3]};
        unique case (key)
            4'h0: cur_tenths = 5'd2;
            4'h8: cur_tenths = 5'd3;
            4'h4: cur_tenths = 5'd4;
            4'h2: cur_tenths = 5'd5;
            4'h1: cur_tenths = 5'd6;
            4'hc: cur_tenths = 5'd8;
            4'hb: cur_tenths = 5'd9;
            4'he: cur_tenths = 5'd10;
            4'h7: cur_tenths = 5'd11;
            4'ha: cur_tenths = 5'd12;
            4'h5: cur_tenths = 5'd13;
            4'h9: cur_tenths = 5'd14;
            4'h6: cur_tenths = 5'd16;
            4'h3: cur_tenths = 5'd18;
            4'hd: cur_tenths = 5'd20;
            4'hf: cur_tenths = 5'd22;
        endcase
    endfunction : cur_tenths

    // Steps per revolution from {sw0,sw1,sw2,sw3}
    function automatic logic [15:0] spr_decode(input logic [3:0] sw);
        logic [3:0] key;
        key = {sw[0], sw[1], sw[2], sw[3]};
        unique case (key)
            4'hf: spr_decode = 16'd200;
            4'h7: spr_decode = 16'd400;
            4'hb: spr_decode = 16'd800;
            4'hd: spr_decode = 16'd1000;
            4'he: spr_decode = 16'd1600;
            4'h3: spr_decode = 16'd2000;
            4'hc: spr_decode = 16'd3200;
            4'h1: spr_decode = 16'd4000;
            4'h8: spr_decode = 16'd5000;
            4'h5: spr_decode = 16'd6400;
            4'ha: spr_decode = 16'd8000;
            4'h6: spr_decode = 16'd10000;
            4'h9: spr_decode = 16'd12800;
            4'h4: spr_decode = 16'd20000;
            4'h2: spr_decode = 16'd25600;
            4'h0: spr_decode = 16'd40000;
        endcase
    endfunction : spr_decode

    // Reset release, asserted at once, freed after two edges
    sdmc_sync #(.W(1)) u_rst_sync (
        .mclk (mclk),
        .rstN (resetn),
        .din  (1'b1),
        .dout (rstN)
    );

    // Pins cross into the clock domain; pulses wider than 2.5 us survive this
    sdmc_sync #(.W(3)) u_ctl_sync (
        .mclk (mclk),
        .rstN (rstN),
        .din  ({stepPulseIn, directionIn, motorReleaseN}),
        .dout ({stepS, dirS, relS})
    );

    sdmc_sync #(.W(6)) u_flt_sync (
        .mclk (mclk),
        .rstN (rstN),
        .din  ({encoderFault, phaseOverTemp, phaseOverCurrent, phaseOpen, overVoltage,
                underVoltage}),
        .dout (faultS)
    );

    sdmc_sync #(.W(8)) u_sw_sync (
        .mclk (mclk),
        .rstN (rstN),
        .din  ({microstepSel, currentSel}),
        .dout (swS)
    );

    assign faultActive = |faultS;
    assign stepFall    = st.stepPrev & ~stepS;
    // One step per edge, no rate limit: 200 kHz is 125 cycles apart
    assign stepTake    = stepFall & relS & ~faultActive & st.ctrlEn;
    assign wrCtrl      = regWrEn && (regAddr == `SDMC_REG_CTRL);
    assign wrStatus    = regWrEn && (regAddr == `SDMC_REG_STATUS);
    assign wrMask      = regWrEn && (regAddr == `SDMC_REG_MASK);
    assign posInc      = (st.microPos >= st.stepsPerRev - 16'h0001) ? 16'h0000
                                                                   : st.microPos + 16'h0001;
    assign posDec      = (st.microPos == 16'h0000 || st.microPos >= st.stepsPerRev)
                         ? st.stepsPerRev - 16'h0001 : st.microPos - 16'h0001;

    always_comb begin
        nxt             = st;
        nxt.stepPrev    = stepS;
        nxt.relPrev     = relS;
        nxt.stepStrobe  = stepTake;
        nxt.runCurrent  = cur_tenths(swS[3:0]);
        nxt.stepsPerRev = spr_decode(swS[7:4]);

        if (stepTake) begin
            nxt.stepUp   = dirS;
            nxt.microPos = dirS ? posInc : posDec;
        end
        if (wrCtrl) begin
            nxt.ctrlEn = regWrData[`SDMC_CTRL_EN_BIT];
            if (regWrData[`SDMC_CTRL_CLRPOS_BIT]) begin
                nxt.microPos = 16'h0000;
            end
        end

        // Idle timer restarts on every accepted step
        if (stepTake) begin
            nxt.idleCnt = 24'h000000;
            nxt.idle    = 1'b0;
        end else if (st.idleCnt >= 24'(IDLE_CYCLES - 1)) begin
            nxt.idle    = 1'b1;
        end else begin
            nxt.idleCnt = st.idleCnt + 24'h000001;
        end

        // Faults and release both kill phase current
        nxt.coilEnable = relS & ~faultActive;
        if (!nxt.coilEnable) begin
            nxt.currentCmd = 6'h00;
        end else if (nxt.idle) begin
            nxt.currentCmd = {1'b0, nxt.runCurrent};
        end else begin
            nxt.currentCmd = {nxt.runCurrent, 1'b0};
        end

        if (st.blinkCnt >= 24'(BLINK_CYCLES - 1)) begin
            nxt.blinkCnt   = 24'h000000;
            nxt.blinkPhase = ~st.blinkPhase;
        end else begin
            nxt.blinkCnt   = st.blinkCnt + 24'h000001;
        end
        nxt.powerLed = nxt.idle ? nxt.blinkPhase : 1'b1;
        nxt.faultLed = faultActive & nxt.blinkPhase;

        // Set wins over a same-cycle clear
        nxt.status = (st.status & ~(wrStatus ? regWrData[7:0] : 8'h00)) | events;
        if (wrMask) begin
            nxt.mask = regWrData[7:0];
        end

        nxt.rdData = 16'h0000;
        if (regRdEn) begin
            case (regAddr)
                `SDMC_REG_CTRL:   nxt.rdData = {15'h0000, st.ctrlEn};
                `SDMC_REG_STATUS: nxt.rdData = {8'h00, st.status};
                `SDMC_REG_MASK:   nxt.rdData = {8'h00, st.mask};
                `SDMC_REG_POS:    nxt.rdData = st.microPos;
                `SDMC_REG_SWITCH: nxt.rdData = {2'b00, st.currentCmd, swS};
                `SDMC_REG_STATE:  nxt.rdData = {11'h000, st.coilEnable, faultActive, dirS,
                                                ~relS, st.idle};
                default:          nxt.rdData = 16'h0000;
            endcase
        end
    end

    always_comb begin
        events                   = 8'h00;
        events[5:0]              = faultS;
        events[`SDMC_EV_IDLE]    = ~st.idle & (st.idleCnt >= 24'(IDLE_CYCLES - 1)) & ~stepTake;
        events[`SDMC_EV_RELEASE] = st.relPrev & ~relS;
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            st <= ST_RST;
        end else begin
            st <= nxt;
        end
    end

    assign regRdData   = st.rdData;
    assign irq         = |(st.status & st.mask);
    assign microPos    = st.microPos;
    assign stepStrobe  = st.stepStrobe;
    assign stepUp      = st.stepUp;
    assign coilEnable  = st.coilEnable;
    assign currentCmd  = st.currentCmd;
    assign runCurrent  = st.runCurrent;
    assign stepsPerRev = st.stepsPerRev;
    assign powerLed    = st.powerLed;
    assign faultLed    = st.faultLed;

    // Checks
    property p_step_adv;
        @(posedge mclk) disable iff (!rstN)
        stepTake && !wrCtrl |=> stepStrobe && (microPos != $past(microPos));
    endproperty
    a_step_adv: assert property (p_step_adv) else $error("step edge not taken");

    property p_dir;
        @(posedge mclk) disable iff (!rstN)
        stepTake |=> stepUp == $past(dirS);
    endproperty
    a_dir: assert property (p_dir) else $error("step sense wrong");

    property p_inc;
        @(posedge mclk) disable iff (!rstN)
        stepStrobe && stepUp && !$past(wrCtrl)
            && ($past(microPos) < $past(stepsPerRev) - 16'h0001)
            |-> microPos == $past(microPos) + 16'h0001;
    endproperty
    a_inc: assert property (p_inc) else $error("up step not plus one");

    property p_rate;
        @(posedge mclk) disable iff (!rstN)
        $fell(stepS) && relS && !faultActive && st.ctrlEn |=> stepStrobe;
    endproperty
    a_rate: assert property (p_rate) else $error("back to back step lost");

    property p_release;
        @(posedge mclk) disable iff (!rstN)
        !relS |=> !coilEnable && !stepStrobe && currentCmd == 6'h00;
    endproperty
    a_release: assert property (p_release) else $error("release left current on");

    property p_idle;
        @(posedge mclk) disable iff (!rstN)
        st.idleCnt == 24'(IDLE_CYCLES - 1) && !stepTake |=> st.idle;
    endproperty
    a_idle: assert property (p_idle) else $error("idle not entered");

    property p_half;
        @(posedge mclk) disable iff (!rstN)
        coilEnable |-> currentCmd == (st.idle ? {1'b0, runCurrent} : {runCurrent, 1'b0});
    endproperty
    a_half: assert property (p_half) else $error("current command wrong");

    property p_spr;
        @(posedge mclk) disable iff (!rstN)
        $stable(swS) |=> stepsPerRev == spr_decode($past(swS[7:4]))
            && runCurrent == cur_tenths($past(swS[3:0]));
    endproperty
    a_spr: assert property (p_spr) else $error("switch decode wrong");

    property p_pled;
        @(posedge mclk) disable iff (!rstN)
        !st.idle |-> powerLed;
    endproperty
    a_pled: assert property (p_pled) else $error("power led not solid");

    property p_fled;
        @(posedge mclk) disable iff (!rstN)
        !faultActive |=> !faultLed;
    endproperty
    a_fled: assert property (p_fled) else $error("fault led without fault");

    property p_prot;
        @(posedge mclk) disable iff (!rstN)
        faultActive |=> !coilEnable;
    endproperty
    a_prot: assert property (p_prot) else $error("fault left current on");

    property p_restart;
        @(posedge mclk) disable iff (!rstN)
        stepStrobe |-> st.idleCnt == 24'h000000 && !st.idle;
    endproperty
    a_restart: assert property (p_restart) else $error("idle timer not restarted");

    property p_cv_up;
        @(posedge mclk) disable iff (!rstN) stepStrobe && stepUp;
    endproperty
    c_cv_up: cover property (p_cv_up);

    property p_cv_down;
        @(posedge mclk) disable iff (!rstN) stepStrobe && !stepUp;
    endproperty
    c_cv_down: cover property (p_cv_down);

    property p_cv_idle;
        @(posedge mclk) disable iff (!rstN) $rose(st.idle) && coilEnable;
    endproperty
    c_cv_idle: cover property (p_cv_idle);

    property p_cv_irq;
        @(posedge mclk) disable iff (!rstN) $rose(irq);
    endproperty
    c_cv_irq: cover property (p_cv_irq);
endmodule : sdmc_motor_ctrl

// *** sim/sdmc_step_source.sv ***
// Behavioural motion controller driving the step and direction pins
`timescale 1ns/1ps
module sdmc_step_source (
    input  wire logic mclk,        // System clock
    output logic      stepPulseIn, // Step pin, idle high
    output logic      directionIn  // Direction pin
);
    initial begin
        stepPulseIn = 1'b1;
        directionIn = 1'b1;
    end

    // Direction settles well before the next falling step edge
    task automatic set_dir(input logic up);
        directionIn <= up;
        repeat (64) @(posedge mclk);
    endtask : set_dir

    // One pulse; caller keeps both phases at 63 cycles or more
    task automatic step_once(input int lowCyc, input int highCyc);
        @(posedge mclk);
        stepPulseIn <= 1'b0;
        repeat (lowCyc) @(posedge mclk);
        stepPulseIn <= 1'b1;
        repeat (highCyc - 1) @(posedge mclk);
    endtask : step_once
endmodule : sdmc_step_source

// *** sim/sdmc_motor_ctrl_tb_top.sv ***
// Self-checking bench for the step/dir motor controller
`timescale 1ns/1ps
`include "sdmc_map.svh"
module sdmc_motor_ctrl_tb_top;
    localparam int IDLE_C  = 200;
    localparam int BLINK_C = 16;

    logic        mclk;
    logic        resetn;
    logic        stepPulseIn;
    logic        directionIn;
    logic        motorReleaseN;
    logic [3:0]  currentSel;
    logic [3:0]  microstepSel;
    logic [5:0]  fault;
    logic [3:0]  regAddr;
    logic [15:0] regWrData;
    logic        regWrEn;
    logic        regRdEn;
    logic [15:0] regRdData;
    logic        irq;
    logic [15:0] microPos;
    logic        stepStrobe;
    logic        stepUp;
    logic        coilEnable;
    logic [5:0]  currentCmd;
    logic [4:0]  runCurrent;
    logic [15:0] stepsPerRev;
    logic        powerLed;
    logic        faultLed;
    logic        rdLate = 1'b0;
    logic [16:0] stepQ[$];
    logic [15:0] rdQ[$];
    int          n_mismatch = 0;
    int          num_checks = 0;
    integer      seed = 32'h0da7;
    int          pos = 0;
    int          spr = 200;
    int          run;
    logic [3:0]  curCode;
    int          curTab[16] = '{2, 3, 4, 8, 5, 12, 16, 10, 6, 14, 13, 20, 18, 9, 11, 22};
    int          msTab[16]  = '{40000, 5000, 20000, 3200, 25600, 8000, 10000, 1600,
                                4000, 12800, 6400, 1000, 2000, 800, 400, 200};

    sdmc_motor_ctrl #(.IDLE_CYCLES(IDLE_C), .BLINK_CYCLES(BLINK_C)) u_dut (
        .mclk(mclk), .resetn(resetn), .stepPulseIn(stepPulseIn), .directionIn(directionIn),
        .motorReleaseN(motorReleaseN), .currentSel(currentSel), .microstepSel(microstepSel),
        .underVoltage(fault[0]), .overVoltage(fault[1]), .phaseOpen(fault[2]),
        .phaseOverCurrent(fault[3]), .phaseOverTemp(fault[4]), .encoderFault(fault[5]),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .irq(irq), .microPos(microPos), .stepStrobe(stepStrobe),
        .stepUp(stepUp), .coilEnable(coilEnable), .currentCmd(currentCmd),
        .runCurrent(runCurrent), .stepsPerRev(stepsPerRev), .powerLed(powerLed),
        .faultLed(faultLed)
    );

    sdmc_step_source u_src (
        .mclk(mclk), .stepPulseIn(stepPulseIn), .directionIn(directionIn)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        regWrEn   <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge mclk);
        regWrEn <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        rdQ.push_back(exp);
        @(posedge mclk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRdEn <= 1'b0;
    endtask : rd

    // Notes the expected position, then issues one pulse of random width
    task automatic step(input logic up);
        if (up) pos = (pos + 1) % spr;
        else pos = (pos == 0) ? spr - 1 : pos - 1;
        stepQ.push_back({up, pos[15:0]});
        u_src.step_once(63 + $unsigned($random(seed)) % 16, 63 + $unsigned($random(seed)) % 16);
    endtask : step

    task automatic blinks(input logic useFault);
        int   n;
        logic last;
        n = 0;
        last = useFault ? faultLed : powerLed;
        repeat (3 * BLINK_C) begin
            @(negedge mclk);
            if ((useFault ? faultLed : powerLed) !== last) n++;
            last = useFault ? faultLed : powerLed;
        end
        chk(n >= 2, 1);
    endtask : blinks

    always @(posedge mclk) rdLate <= regRdEn;

    // Result watcher: each strobe or read answer retires the oldest note
    always @(negedge mclk) begin
        if (stepStrobe === 1'b1) begin
            if (stepQ.size() == 0) chk(32'h1, 32'h0);
            else chk({stepUp, microPos}, stepQ.pop_front());
        end
        if (rdLate) chk(regRdData, rdQ.pop_front());
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        conclude();
    end

    initial begin
        regAddr       = 4'h0;
        regWrData     = 16'h0000;
        regWrEn       = 1'b0;
        regRdEn       = 1'b0;
        motorReleaseN = 1'b1;
        currentSel    = 4'h0;
        microstepSel  = 4'hf;
        fault         = 6'h00;
        resetn        = 1'b0;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        repeat (10) @(posedge mclk);
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk);
            microstepSel <= 4'(i);
            currentSel   <= 4'(i);
            repeat (6) @(negedge mclk);
            chk(stepsPerRev, msTab[i]);
            chk(runCurrent, curTab[i]);
        end
        curCode = 4'($random(seed));
        run = curTab[curCode];
        @(posedge mclk);
        microstepSel <= 4'hf;
        currentSel   <= curCode;
        repeat (6) @(negedge mclk);
        // Down through zero, then up across the wrap point
        u_src.set_dir(1'b0);
        repeat (3) step(1'b0);
        u_src.set_dir(1'b1);
        repeat (4 + $unsigned($random(seed)) % 5) step(1'b1);
        chk(currentCmd, 2 * run);
        chk(powerLed, 1);
        rd(`SDMC_REG_POS, 16'(pos));
        rd(`SDMC_REG_SWITCH, {2'b00, 6'(2 * run), 4'hf, curCode});
        wr(`SDMC_REG_STATUS, 16'h00ff);
        repeat (IDLE_C + 10) @(negedge mclk);
        chk(currentCmd, run);
        blinks(1'b0);
        rd(`SDMC_REG_STATUS, 16'h0040);
        wr(`SDMC_REG_MASK, 16'h0040);
        @(negedge mclk);
        chk(irq, 1);
        wr(`SDMC_REG_STATUS, 16'h0040);
        @(negedge mclk);
        chk(irq, 0);
        step(1'b1);
        chk(currentCmd, 2 * run);
        chk(powerLed, 1);
        // Release: coil off, steps ignored
        wr(`SDMC_REG_MASK, 16'h0080);
        @(posedge mclk);
        motorReleaseN <= 1'b0;
        repeat (6) @(negedge mclk);
        chk(coilEnable, 0);
        chk(currentCmd, 0);
        chk(irq, 1);
        rd(`SDMC_REG_STATE, 16'h0006);
        u_src.step_once(63, 63);
        @(posedge mclk);
        motorReleaseN <= 1'b1;
        wr(`SDMC_REG_STATUS, 16'h00ff);
        wr(`SDMC_REG_MASK, 16'h003f);
        for (int i = 0; i < 6; i++) begin
            @(posedge mclk);
            fault <= 6'(1 << i);
            repeat (6) @(negedge mclk);
            chk(coilEnable, 0);
            chk(currentCmd, 0);
            chk(irq, 1);
            blinks(1'b1);
            u_src.step_once(63, 63);
            @(posedge mclk);
            fault <= 6'h00;
            repeat (6) @(negedge mclk);
            wr(`SDMC_REG_STATUS, 16'h00ff);
            @(negedge mclk);
            chk(irq, 0);
            chk(faultLed, 0);
            chk(coilEnable, 1);
        end
        // Disabled steps are dropped; position clear and unmapped reads
        wr(`SDMC_REG_CTRL, 16'h0000);
        u_src.step_once(63, 63);
        wr(`SDMC_REG_CTRL, 16'h0003);
        pos = 0;
        rd(`SDMC_REG_POS, 16'h0000);
        rd(`SDMC_REG_CTRL, 16'h0001);
        rd(4'hf, 16'h0000);
        step(1'b1);
        rd(`SDMC_REG_POS, 16'h0001);
        repeat (4) @(negedge mclk);
        chk(stepQ.size(), 0);
        conclude();
    end
endmodule : sdmc_motor_ctrl_tb_top
